// [design/cssm_core_status.sv]
`timescale 1ns/100ps
module cssm_core_status
  import cssm_pkg::*;
#(
  parameter bit          FLASH_64K   = 1'b1,
  parameter logic [31:0] SERIAL_INIT = SERIAL_RESET
)(
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            arst_n,
  // Special register access
  input  wire logic [7:0]      sfr_addr,
  input  wire logic [7:0]      sfr_page,
  input  wire logic            sfr_wr,
  input  wire logic            sfr_rd,
  input  wire logic [7:0]      sfr_wdata,
  output logic [7:0]           sfr_rdata,
  // Core execution
  input  wire logic [7:0]      acc_value,
  input  wire cssm_op_type     alu_op,
  input  wire logic [7:0]      alu_a,
  input  wire logic [7:0]      alu_b,
  input  wire logic            alu_carry,
  // Working register addressing
  input  wire logic [2:0]      reg_index,
  output logic [7:0]           reg_data_addr,
  // Program memory access
  input  wire logic [15:0]     code_addr,
  input  wire cssm_access_type access_kind,
  input  wire logic            flash_wr_en,
  output logic                 flash_read,
  output logic                 flash_write,
  output logic                 expansion_data_ram_read,
  output logic                 expansion_data_ram_write,
  output logic                 lock_hit,
  output logic                 reserved_hit,
  // Status view
  output logic [1:0]           bank_select,
  output logic                 arith_range_flag,
  output logic                 user_flag_one,
  output logic                 parity_flag,
  output logic [31:0]          serial_number
);

  // Serial storage, one byte per register
  logic [7:0] serial_byte [4];
  logic [7:0] next_serial_byte [4];

  logic [1:0] next_bank_select;
  logic       next_arith_range_flag;
  logic       next_user_flag_one;
  logic       next_parity_flag;
  logic [7:0] next_sfr_rdata;
  logic [7:0] next_reg_data_addr;
  logic       ov_event;
  logic       ov_value;
  logic       psw_hit;
  logic       serial_page_hit;
  logic       live_parity;
  logic       rt_flash_read;
  logic       rt_flash_write;
  logic       rt_expansion_data_ram_read;
  logic       rt_expansion_data_ram_write;
  logic       rt_lock;
  logic       rt_reserved;

  // Overflow decision for the instruction in flight
  cssm_alu_flag u_alu_flag (
    .op       (alu_op),
    .opnd_a   (alu_a),
    .opnd_b   (alu_b),
    .carry_in (alu_carry),
    .ov_event (ov_event),
    .ov_value (ov_value)
  );

  // Program memory routing
  cssm_mem_route #(
    .FLASH_64K (FLASH_64K)
  ) u_mem_route (
    .addr           (code_addr),
    .kind           (access_kind),
    .flash_wr_en    (flash_wr_en),
    .to_flash_read  (rt_flash_read),
    .to_flash_write (rt_flash_write),
    .to_expansion_data_ram_read   (rt_expansion_data_ram_read),
    .to_expansion_data_ram_write  (rt_expansion_data_ram_write),
    .is_lock        (rt_lock),
    .is_reserved    (rt_reserved)
  );

  // Address decode; status word is visible on every page
  assign psw_hit         = (sfr_addr == PSW_OFFSET);
  assign serial_page_hit = (sfr_page == SERIAL_PAGE);
  assign live_parity     = ^acc_value;

  // Status word next state; an instruction outcome beats a software write to overflow
  always_comb begin
    next_bank_select      = bank_select;
    next_arith_range_flag = arith_range_flag;
    next_user_flag_one    = user_flag_one;
    if (sfr_wr && psw_hit) begin
      next_bank_select      = sfr_wdata[PSW_BANK_HI:PSW_BANK_LO];
      next_arith_range_flag = sfr_wdata[PSW_OV_BIT];
      next_user_flag_one    = sfr_wdata[PSW_UF1_BIT];
    end
    if (ov_event) begin
      next_arith_range_flag = ov_value;
    end
    next_parity_flag = live_parity;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_select      <= BANK_RESET;
      arith_range_flag <= FLAG_RESET;
      user_flag_one    <= FLAG_RESET;
      parity_flag      <= FLAG_RESET;
    end else begin
      bank_select      <= next_bank_select;
      arith_range_flag <= next_arith_range_flag;
      user_flag_one    <= next_user_flag_one;
      parity_flag      <= next_parity_flag;
    end
  end

  // Serial bytes: factory value at power-up, plain storage afterwards
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_serial_byte[i] = serial_byte[i];
    end
    if (sfr_wr && serial_page_hit) begin
      unique case (sfr_addr)
        SERIAL_0_OFFSET: next_serial_byte[0] = sfr_wdata;
        SERIAL_1_OFFSET: next_serial_byte[1] = sfr_wdata;
        SERIAL_2_OFFSET: next_serial_byte[2] = sfr_wdata;
        SERIAL_3_OFFSET: next_serial_byte[3] = sfr_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        serial_byte[i] <= SERIAL_INIT[i*8 +: 8];
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        serial_byte[i] <= next_serial_byte[i];
      end
    end
  end

  // Byte 3 on top, byte 0 at the bottom
  assign serial_number = {serial_byte[3], serial_byte[2], serial_byte[1], serial_byte[0]};

  // Read data; unmapped addresses read zero, bits above the bank field read zero
  always_comb begin
    next_sfr_rdata = RDATA_RESET;
    if (sfr_rd) begin
      if (psw_hit) begin
        next_sfr_rdata = {3'h0, bank_select, arith_range_flag, user_flag_one, live_parity};
      end else if (serial_page_hit) begin
        unique case (sfr_addr)
          SERIAL_0_OFFSET: next_sfr_rdata = serial_byte[0];
          SERIAL_1_OFFSET: next_sfr_rdata = serial_byte[1];
          SERIAL_2_OFFSET: next_sfr_rdata = serial_byte[2];
          SERIAL_3_OFFSET: next_sfr_rdata = serial_byte[3];
          default: ;
        endcase
      end
    end
  end

  // Working register address: bank n starts at eight times n
  always_comb begin
    next_reg_data_addr = {3'h0, bank_select, reg_index};
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata     <= RDATA_RESET;
      reg_data_addr <= RDATA_RESET;
    end else begin
      sfr_rdata     <= next_sfr_rdata;
      reg_data_addr <= next_reg_data_addr;
    end
  end

  // Memory routing registered so every output leaves a flop
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_read   <= FLAG_RESET;
      flash_write  <= FLAG_RESET;
      expansion_data_ram_read    <= FLAG_RESET;
      expansion_data_ram_write   <= FLAG_RESET;
      lock_hit     <= FLAG_RESET;
      reserved_hit <= FLAG_RESET;
    end else begin
      flash_read   <= rt_flash_read;
      flash_write  <= rt_flash_write;
      expansion_data_ram_read    <= rt_expansion_data_ram_read;
      expansion_data_ram_write   <= rt_expansion_data_ram_write;
      lock_hit     <= rt_lock;
      reserved_hit <= rt_reserved;
    end
  end

  // Checks

  // Sign-extended arithmetic for the checks, kept apart from the flag logic on purpose
  logic [8:0] sum_sign_ext;
  logic [8:0] diff_sign_ext;
  assign sum_sign_ext  = {alu_a[7], alu_a} + {alu_b[7], alu_b} +
                         {8'h00, (alu_op == OP_ADDC) & alu_carry};
  assign diff_sign_ext = {alu_a[7], alu_a} - {alu_b[7], alu_b} - {8'h00, alu_carry};

  sequence seq_psw_store;
    sfr_wr && psw_hit && (alu_op == OP_NONE);
  endsequence

  sequence seq_serial_store;
    sfr_wr && serial_page_hit && (sfr_addr == SERIAL_3_OFFSET);
  endsequence

  sequence seq_serial_fetch;
    sfr_rd && !sfr_wr && serial_page_hit && (sfr_addr == SERIAL_3_OFFSET);
  endsequence

  chk_bank_base: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ##1 reg_data_addr == ({3'h0, $past(bank_select), 3'h0} + {5'h00, $past(reg_index)}))
    else $error("working register address not at bank base");

  chk_bank_three: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bank_select == 2'h3) |=> (reg_data_addr >= 8'h18) && (reg_data_addr <= 8'h1F))
    else $error("bank three outside 0x18-0x1F");

  chk_div_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (alu_op == OP_DIV) && (alu_b == 8'h00) |=> arith_range_flag)
    else $error("divide by zero left overflow clear");

  chk_ov_cleared: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (alu_op == OP_DIV) && (alu_b != 8'h00) |=> !arith_range_flag)
    else $error("overflow not cleared by clean divide");

  chk_mul_range: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (alu_op == OP_MUL) |=>
      arith_range_flag == ((({8'h00, $past(alu_a)} * {8'h00, $past(alu_b)}) > 16'h00FF)))
    else $error("multiply overflow wrong");

  chk_add_signed: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (alu_op == OP_ADD) && (alu_a == 8'h7F) && (alu_b == 8'h01) |=> arith_range_flag)
    else $error("signed add overflow missed");

  chk_add_range: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((alu_op == OP_ADD) || (alu_op == OP_ADDC)) |=>
      arith_range_flag == ($past(sum_sign_ext[8]) != $past(sum_sign_ext[7])))
    else $error("add overflow differs from signed range");

  chk_sub_range: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (alu_op == OP_SUBB) |=>
      arith_range_flag == ($past(diff_sign_ext[8]) != $past(diff_sign_ext[7])))
    else $error("subtract overflow differs from signed range");

  chk_ov_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (alu_op == OP_NONE) && !(sfr_wr && psw_hit) |=> $stable(arith_range_flag))
    else $error("overflow changed with no instruction");

  chk_psw_store: assert property (@(posedge ref_clk) disable iff (!arst_n)
    seq_psw_store |=> (bank_select == $past(sfr_wdata[PSW_BANK_HI:PSW_BANK_LO])) &&
      (user_flag_one == $past(sfr_wdata[PSW_UF1_BIT])) &&
      (arith_range_flag == $past(sfr_wdata[PSW_OV_BIT])))
    else $error("status word write not stored");

  chk_parity_track: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ##1 parity_flag == ^$past(acc_value))
    else $error("parity does not follow accumulator");

  chk_serial_store: assert property (@(posedge ref_clk) disable iff (!arst_n)
    seq_serial_store |=> serial_number[31:24] == $past(sfr_wdata))
    else $error("serial byte write lost");

  chk_serial_order: assert property (@(posedge ref_clk) disable iff (!arst_n)
    seq_serial_fetch |=> sfr_rdata == $past(serial_number[31:24]))
    else $error("serial byte three not the top byte");

  chk_ext_no_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (access_kind == ACC_EXT_READ) |=> !flash_read && expansion_data_ram_read)
    else $error("external read reached flash");

  chk_ext_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (access_kind == ACC_EXT_WRITE) && !flash_wr_en |=> expansion_data_ram_write && !flash_write)
    else $error("plain external write left expansion RAM");

  chk_flash_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (access_kind == ACC_EXT_WRITE) && flash_wr_en &&
      (code_addr <= (FLASH_64K ? RESERVED_ABOVE : FLASH_END_SMALL))
      |=> flash_write && !expansion_data_ram_write)
    else $error("redirected external write missed flash");

  chk_reserved_top: assert property (@(posedge ref_clk) disable iff (!arst_n)
    FLASH_64K && (access_kind == ACC_CODE_READ) && (code_addr > RESERVED_ABOVE)
      |=> reserved_hit && !flash_read)
    else $error("reserved program area reachable");

  chk_lock_byte: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (access_kind == ACC_CODE_READ) &&
      (code_addr == (FLASH_64K ? LOCK_LARGE : LOCK_SMALL)) |=> lock_hit)
    else $error("lock byte not flagged");

  // Usable top is the reserved boundary on the large part and the flash end on the small one
  chk_flash_end: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (access_kind == ACC_CODE_READ) &&
      (code_addr > (FLASH_64K ? RESERVED_ABOVE : FLASH_END_SMALL))
      |=> !flash_read)
    else $error("read beyond usable flash");

endmodule : cssm_core_status

// [design/cssm_pkg.sv]
// Function
// - Bank select 10 maps the working registers to bank 2 and 11 maps them to 0x18-0x1F.
// - Data bytes 0x00-0x1F form four eight-register banks, bank n starting at eight times n.
// - A divide with a zero divisor sets the overflow status bit.
// - Add, add-with-carry, subtract-with-borrow, multiply and divide clear overflow otherwise.
// - Four serial bytes power up holding a per-device 32-bit value that firmware can read.
// - The serial bytes are writable so firmware may use them as general storage.
// - The serial number is byte 3 as most significant down to byte 0 as least significant.
// - Program and data spaces share numbers; the instruction type picks the space.
// - Flash spans 0x0000-0xFFFF on the large variant and 0x0000-0x7FFF on the small one.
// - The lock byte sits at 0xFBFF on the large variant and 0x7FFF on the small one.
// - On the large variant program addresses above 0xFDFF are reserved and unusable.
// - External moves reach expansion RAM; reconfigured, their writes go to flash.
// - Flash is read only by the code-memory move, never by the external move.
package cssm_pkg;

  // Special register map
  localparam logic [7:0] PSW_OFFSET      = 8'hD0;
  localparam logic [7:0] SERIAL_0_OFFSET = 8'hF9;
  localparam logic [7:0] SERIAL_1_OFFSET = 8'hFA;
  localparam logic [7:0] SERIAL_2_OFFSET = 8'hFB;
  localparam logic [7:0] SERIAL_3_OFFSET = 8'hFC;
  localparam logic [7:0] SERIAL_PAGE     = 8'h0F;

  // Status word field positions
  localparam int PSW_BANK_HI  = 4;
  localparam int PSW_BANK_LO  = 3;
  localparam int PSW_OV_BIT   = 2;
  localparam int PSW_UF1_BIT  = 1;
  localparam int PSW_PAR_BIT  = 0;

  // Reset values
  localparam logic [1:0]  BANK_RESET   = 2'h0;
  localparam logic        FLAG_RESET   = 1'b0;
  localparam logic [7:0]  RDATA_RESET  = 8'h00;
  localparam logic [31:0] SERIAL_RESET = 32'h5A3C_96E1; // Arbitrary neutral value

  // Program memory map
  localparam logic [15:0] FLASH_END_LARGE = 16'hFFFF;
  localparam logic [15:0] FLASH_END_SMALL = 16'h7FFF;
  localparam logic [15:0] LOCK_LARGE      = 16'hFBFF;
  localparam logic [15:0] LOCK_SMALL      = 16'h7FFF;
  localparam logic [15:0] RESERVED_ABOVE  = 16'hFDFF;

  // Arithmetic instructions that touch overflow
  typedef enum logic [2:0] {
    OP_NONE, OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV
  } cssm_op_type;

  // Memory access kind, decoded from the instruction type
  typedef enum logic [1:0] {
    ACC_NONE, ACC_CODE_READ, ACC_EXT_READ, ACC_EXT_WRITE
  } cssm_access_type;

endpackage : cssm_pkg

// [design/cssm_alu_flag.sv]
`timescale 1ns/100ps
module cssm_alu_flag
  import cssm_pkg::*;
(
  // Operation
  input  cssm_op_type op,
  input  logic [7:0]  opnd_a,
  input  logic [7:0]  opnd_b,
  input  logic        carry_in,
  // Result
  output logic        ov_event,
  output logic        ov_value
);

  logic [8:0]  sum;
  logic [8:0]  diff;
  logic [15:0] prod;

  // Widened so the carry and the high product byte are kept
  assign sum  = {1'b0, opnd_a} + {1'b0, opnd_b} + {8'h00, (op == OP_ADDC) & carry_in};
  assign diff = {1'b0, opnd_a} - {1'b0, opnd_b} - {8'h00, carry_in};
  assign prod = {8'h00, opnd_a} * {8'h00, opnd_b};

  // Overflow decision per instruction; every op except OP_NONE rewrites the flag
  always_comb begin
    ov_event = 1'b1;
    ov_value = 1'b0;
    unique case (op)
      OP_NONE: ov_event = 1'b0;
      OP_ADD, OP_ADDC: ov_value = (opnd_a[7] == opnd_b[7]) && (sum[7] != opnd_a[7]);
      OP_SUBB: ov_value = (opnd_a[7] != opnd_b[7]) && (diff[7] != opnd_a[7]);
      OP_MUL:  ov_value = |prod[15:8];
      OP_DIV:  ov_value = (opnd_b == 8'h00);
      default: ov_event = 1'b0;
    endcase
  end

endmodule : cssm_alu_flag

// [design/cssm_mem_route.sv]
`timescale 1ns/100ps
module cssm_mem_route
  import cssm_pkg::*;
#(
  parameter bit FLASH_64K = 1'b1
)(
  // Access
  input  logic [15:0]     addr,
  input  cssm_access_type kind,
  input  logic            flash_wr_en,
  // Routing
  output logic            to_flash_read,
  output logic            to_flash_write,
  output logic            to_expansion_data_ram_read,
  output logic            to_expansion_data_ram_write,
  output logic            is_lock,
  output logic            is_reserved
);

  logic [15:0] flash_end;
  logic [15:0] lock_addr;
  logic        in_flash;
  logic        want_flash;

  assign flash_end = FLASH_64K ? FLASH_END_LARGE : FLASH_END_SMALL;
  assign lock_addr = FLASH_64K ? LOCK_LARGE : LOCK_SMALL;
  assign in_flash  = (addr <= flash_end);

  // The instruction type, with flash_wr_en for external writes, picks program or data space
  always_comb begin
    want_flash     = (kind == ACC_CODE_READ) ||
                     ((kind == ACC_EXT_WRITE) && flash_wr_en);
    is_reserved    = want_flash && FLASH_64K && (addr > RESERVED_ABOVE);
    to_flash_read  = (kind == ACC_CODE_READ) && in_flash && !is_reserved;
    to_flash_write = (kind == ACC_EXT_WRITE) && flash_wr_en && in_flash && !is_reserved;
    to_expansion_data_ram_read   = (kind == ACC_EXT_READ);
    to_expansion_data_ram_write  = (kind == ACC_EXT_WRITE) && !flash_wr_en;
    is_lock        = want_flash && (addr == lock_addr);
  end

endmodule : cssm_mem_route

// [testbench/cssm_core_status_bench.sv]
`timescale 1ns/100ps
module cssm_core_status_bench
  import cssm_pkg::*;
;
  // Stimulus
  logic            ref_clk;
  logic            arst_n;
  logic [7:0]      sfr_addr;
  logic [7:0]      sfr_page;
  logic            sfr_wr;
  logic            sfr_rd;
  logic [7:0]      sfr_wdata;
  logic [7:0]      acc_value;
  cssm_op_type     alu_op;
  logic [7:0]      alu_a;
  logic [7:0]      alu_b;
  logic            alu_carry;
  logic [2:0]      reg_index;
  logic [15:0]     code_addr;
  cssm_access_type access_kind;
  logic            flash_wr_en;
  // Observed
  logic [7:0]      sfr_rdata;
  logic [7:0]      reg_data_addr;
  logic            flash_read;
  logic            flash_write;
  logic            expansion_data_ram_read;
  logic            expansion_data_ram_write;
  logic            lock_hit;
  logic            reserved_hit;
  logic [1:0]      bank_select;
  logic            arith_range_flag;
  logic            user_flag_one;
  logic            parity_flag;
  logic [31:0]     serial_number;
  // Bookkeeping
  int              bad_count;
  int              cmp_count;
  int              cycles;
  logic [7:0]      rd;

  cssm_core_status u_cssm_core_status (
    .ref_clk(ref_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .acc_value(acc_value), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
    .alu_carry(alu_carry), .reg_index(reg_index), .reg_data_addr(reg_data_addr),
    .code_addr(code_addr), .access_kind(access_kind), .flash_wr_en(flash_wr_en),
    .flash_read(flash_read), .flash_write(flash_write), .expansion_data_ram_read(expansion_data_ram_read),
    .expansion_data_ram_write(expansion_data_ram_write), .lock_hit(lock_hit), .reserved_hit(reserved_hit),
    .bank_select(bank_select), .arith_range_flag(arith_range_flag),
    .user_flag_one(user_flag_one), .parity_flag(parity_flag), .serial_number(serial_number)
  );

  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // One-cycle write strobe, launched at the falling edge
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr  = a;
    sfr_page  = p;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge ref_clk);
    sfr_wr    = 1'b0;
  endtask : sfr_write

  // Read data is registered, so it is settled at the next falling edge
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] p, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_page = p;
    sfr_rd   = 1'b1;
    @(negedge ref_clk);
    sfr_rd   = 1'b0;
    d        = sfr_rdata;
  endtask : sfr_read

  task automatic alu_step(input cssm_op_type op, input logic [7:0] a, input logic [7:0] b,
                          input logic c, input logic exp);
    @(negedge ref_clk);
    alu_op    = op;
    alu_a     = a;
    alu_b     = b;
    alu_carry = c;
    @(negedge ref_clk);
    alu_op    = OP_NONE;
    chk("overflow flag", 32'(exp), 32'(arith_range_flag));
  endtask : alu_step

  // Expected order: flash read, flash write, expansion_data_ram read, expansion_data_ram write, lock, reserved
  task automatic mem_step(input cssm_access_type k, input logic [15:0] a, input logic fw,
                          input logic [5:0] exp);
    @(negedge ref_clk);
    access_kind = k;
    code_addr   = a;
    flash_wr_en = fw;
    @(negedge ref_clk);
    access_kind = ACC_NONE;
    chk("memory route", 32'(exp), 32'({flash_read, flash_write, expansion_data_ram_read, expansion_data_ram_write,
                                       lock_hit, reserved_hit}));
  endtask : mem_step

  task automatic test_serial();
    chk("serial at power-up", SERIAL_RESET, serial_number);
    for (int i = 0; i < 4; i++) begin
      sfr_read(SERIAL_0_OFFSET + 8'(i), SERIAL_PAGE, rd);
      chk("serial byte read", 32'(SERIAL_RESET[8*i +: 8]), 32'(rd));
    end
    sfr_read(SERIAL_3_OFFSET, 8'h00, rd);
    chk("wrong page read", 32'h0000_0000, 32'(rd));
    sfr_write(SERIAL_0_OFFSET, 8'h00, 8'h77);
    chk("wrong page write", SERIAL_RESET, serial_number);
    for (int i = 0; i < 4; i++) begin
      sfr_write(SERIAL_0_OFFSET + 8'(i), SERIAL_PAGE, 8'hC0 + 8'(i));
    end
    chk("serial assembled", 32'hC3C2_C1C0, serial_number);
    sfr_read(SERIAL_2_OFFSET, SERIAL_PAGE, rd);
    chk("serial storage", 32'h0000_00C2, 32'(rd));
    $display("serial test done");
  endtask : test_serial

  // Bank n puts R7 at eight times n plus seven
  task automatic test_banks();
    reg_index = 3'h7;
    for (int b = 0; b < 4; b++) begin
      sfr_write(PSW_OFFSET, 8'h00, 8'(b << 3));
      @(negedge ref_clk);
      chk("bank select", 32'(b), 32'(bank_select));
      chk("register address", 32'(8 * b + 7), 32'(reg_data_addr));
    end
    $display("bank test done");
  endtask : test_banks

  task automatic test_overflow();
    alu_step(OP_ADD,  8'h7F, 8'h01, 1'b0, 1'b1);
    alu_step(OP_ADD,  8'h01, 8'h01, 1'b0, 1'b0);
    alu_step(OP_ADD,  8'h80, 8'h80, 1'b0, 1'b1);
    alu_step(OP_ADDC, 8'h7E, 8'h00, 1'b1, 1'b0);
    alu_step(OP_ADDC, 8'h7E, 8'h01, 1'b1, 1'b1);
    alu_step(OP_SUBB, 8'h00, 8'h7F, 1'b1, 1'b0);
    alu_step(OP_SUBB, 8'h80, 8'h01, 1'b0, 1'b1);
    alu_step(OP_SUBB, 8'h05, 8'h01, 1'b0, 1'b0);
    alu_step(OP_SUBB, 8'h7F, 8'hFF, 1'b0, 1'b1);
    alu_step(OP_MUL,  8'h0F, 8'h11, 1'b0, 1'b0);
    alu_step(OP_MUL,  8'h10, 8'h10, 1'b0, 1'b1);
    alu_step(OP_DIV,  8'h05, 8'h02, 1'b0, 1'b0);
    alu_step(OP_DIV,  8'h05, 8'h00, 1'b0, 1'b1);
    alu_step(OP_NONE, 8'h00, 8'h00, 1'b0, 1'b1);
    alu_step(OP_DIV,  8'hFF, 8'h01, 1'b0, 1'b0);
    $display("overflow test done");
  endtask : test_overflow

  // Parity bit ignores writes and follows the accumulator live
  task automatic test_status_word();
    acc_value = 8'h07;
    sfr_write(PSW_OFFSET, 8'h00, 8'hFE);
    chk("user flag", 32'h1, 32'(user_flag_one));
    sfr_read(PSW_OFFSET, 8'h0C, rd);
    chk("status word odd", 32'h0000_001F, 32'(rd));
    chk("parity flag odd", 32'h1, 32'(parity_flag));
    acc_value = 8'h03;
    sfr_read(PSW_OFFSET, 8'h00, rd);
    chk("status word even", 32'h0000_001E, 32'(rd));
    chk("parity flag even", 32'h0, 32'(parity_flag));
    sfr_write(PSW_OFFSET, 8'h00, 8'h01);
    sfr_read(PSW_OFFSET, 8'h00, rd);
    chk("status word cleared", 32'h0000_0000, 32'(rd));
    $display("status word test done");
  endtask : test_status_word

  task automatic test_memory();
    mem_step(ACC_CODE_READ, 16'h1234, 1'b0, 6'b100000);
    mem_step(ACC_EXT_READ,  16'h1234, 1'b0, 6'b001000);
    mem_step(ACC_EXT_WRITE, 16'h1234, 1'b0, 6'b000100);
    mem_step(ACC_EXT_WRITE, 16'h1234, 1'b1, 6'b010000);
    mem_step(ACC_EXT_READ,  16'h1234, 1'b1, 6'b001000);
    mem_step(ACC_CODE_READ, 16'h0000, 1'b0, 6'b100000);
    mem_step(ACC_CODE_READ, 16'hFBFF, 1'b0, 6'b100010);
    mem_step(ACC_EXT_WRITE, 16'hFBFF, 1'b1, 6'b010010);
    mem_step(ACC_CODE_READ, 16'hFDFF, 1'b0, 6'b100000);
    mem_step(ACC_CODE_READ, 16'hFE00, 1'b0, 6'b000001);
    mem_step(ACC_EXT_WRITE, 16'hFFFF, 1'b1, 6'b000001);
    mem_step(ACC_EXT_READ,  16'hFE00, 1'b0, 6'b001000);
    $display("memory test done");
  endtask : test_memory

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    arst_n      = 1'b0;
    sfr_addr    = 8'h00;
    sfr_page    = 8'h00;
    sfr_wr      = 1'b0;
    sfr_rd      = 1'b0;
    sfr_wdata   = 8'h00;
    acc_value   = 8'h00;
    alu_op      = OP_NONE;
    alu_a       = 8'h00;
    alu_b       = 8'h00;
    alu_carry   = 1'b0;
    reg_index   = 3'h0;
    code_addr   = 16'h0000;
    access_kind = ACC_NONE;
    flash_wr_en = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk("status in reset", 32'h0, 32'({bank_select, arith_range_flag, user_flag_one}));
    arst_n = 1'b1;
    test_serial();
    test_banks();
    test_overflow();
    test_status_word();
    test_memory();
    summarize();
  end

endmodule : cssm_core_status_bench
